// ==== logic/wd_defines.svh ====
// Constants of the watchdog/interval timer: register indices, keys, field positions,
// reset values and timing counts. Included by the package, the prescaler and the timer.
`ifndef WD_DEFINES_SVH
`define WD_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define WD_IDX_CTRL 16'hffa8
`define WD_IDX_CNT 16'hffa9
`define WD_IDX_RST 16'hffab
`define WD_IDX_STAT 16'hffac
`define WD_IDX_MASK 16'hffad

// Keys carried in the upper byte of a word write.
`define WD_KEY_CNT 8'h5a
`define WD_KEY_CTRL 8'ha5

// Control/status field positions.
`define WD_CTRL_OVF 7
`define WD_CTRL_MODE 6
`define WD_CTRL_RUN 5
`define WD_RST_FLAG 7
`define WD_RST_OE 6
`define WD_CTRL_RSVD 2'h3
`define WD_RST_RSVD 6'h3f

// Interrupt status bits.
`define WD_EV_OVF 0
`define WD_EV_WDRST 1

// Reset values.
`define WD_CNT_RESET 8'h00

// Prescaler tap widths, four bits per entry, entry 0 lowest: /2 ... /4096.
`define WD_DIV_TAPS {4'hc, 4'hb, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h1}
`define WD_DIV_BITS 12

// Timing: one state is one system clock cycle.
`define WD_STATE_CYCLES 1
`define WD_RESET_STATES 518
`define WD_RESET_CYCLES (`WD_RESET_STATES * `WD_STATE_CYCLES)
`define WD_EXT_RESET_STATES 132
`define WD_EXT_RESET_CYCLES (`WD_EXT_RESET_STATES * `WD_STATE_CYCLES)

// Bus responses.
`define WD_RESP_OKAY 2'h0
`define WD_RESP_SLVERR 2'h2

`endif

// ==== logic/wd_pkg.sv ====
// Types shared by the watchdog/interval timer design.
// Assumes wd_defines.svh is on the include path.
`include "wd_defines.svh"

package wd_pkg;

  // Control/status register contents held by the timer.
  typedef struct packed {
    logic ovf;
    logic mode;
    logic run;
    logic [2:0] cks;
  } wd_ctrl_t;

  // Reset control/status register contents.
  typedef struct packed {
    logic watchdog_reset_status;
    logic rstoe;
  } wd_rst_t;

  // Write channel progress of the bus slave.
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

endpackage

// ==== logic/wd_prescaler.sv ====
// Prescaler: divides the system clock and emits one-cycle count pulses at the
// rate chosen by a 3-bit select. Assumes the select is changed only while halted.
`timescale 1ns/10ps
`default_nettype none
`include "wd_defines.svh"

module wd_prescaler
  import wd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] cks,
  output logic tick
);

  localparam logic [31:0] TAPS = `WD_DIV_TAPS;

  logic [`WD_DIV_BITS-1:0] div_q;
  logic [7:0] hit;

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  // Held at zero while halted so that every restart begins a full period.
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // One tap per division; a tap fires when its low bits are all ones.
  for (genvar i = 0; i < 8; i++) begin : g_tap
    localparam int B = int'(TAPS[i*4 +: 4]);
    assign hit[i] = &div_q[B-1:0];
  end

  assign tick = run && hit[cks];

  // Divide-by-2 pulses never come back to back.
  a_tick_div2: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && cks == 3'h0 && $stable(cks)) |=> !tick)
    else $error("prescaler tick rate wrong for divide by two");

endmodule

`default_nettype wire

// ==== logic/wd_pulse_gen.sv ====
// Pulse stretcher: a start pulse yields a level held for LEN clock cycles.
// Assumes start is a single-cycle event; starts during a pulse are ignored.
`timescale 1ns/10ps
`default_nettype none

module wd_pulse_gen
  import wd_pkg::*;
#(
  parameter int LEN = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic active
);

  logic [11:0] cnt_q;
  logic busy_q;

  // Count down from LEN-1 while busy; the level falls after the last one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      cnt_q <= 12'h000;
    end else if (start && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q <= 12'(LEN - 1);
    end else if (busy_q) begin
      if (cnt_q == 12'h000) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 12'h001;
      end
    end
  end

  assign active = busy_q;

endmodule

`default_nettype wire

// ==== logic/wd_timer.sv ====
// Watchdog/interval timer with an AXI4-Lite register slave.
// Assumes one clock (aclk) and the external reset on aresetn; the internal
// chip reset it produces is returned to the chip, not to this block's bus.
`timescale 1ns/10ps
`default_nettype none
`include "wd_defines.svh"

module wd_timer
  import wd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic interval_interrupt,
  output logic chip_reset,
  output logic ext_reset_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wd_ctrl_t ctrl_q;
  wd_rst_t rst_q;
  logic [7:0] wd_up_counter_q;
  logic ovf_read_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  wr_state_t wr_state_q;
  logic aw_held_q;
  logic w_held_q;
  logic [17:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ext_active;
  logic [11:0] rst_len_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_fire;
  logic word_ok;
  logic [7:0] wr_key;
  logic [7:0] wr_low;
  logic hit_ctrl;
  logic hit_rst;
  logic hit_stat;
  logic hit_mask;
  logic wr_mapped;
  logic ctrl_wr;
  logic cnt_wr;
  logic tick;
  logic overflow;
  logic wd_event;
  logic ovf_clr;
  logic watchdog_reset_status_clr;

  // A write completes only when both address and data are held.
  assign wr_fire = aw_held_q && w_held_q && (wr_state_q == WR_IDLE);
  assign word_ok = &w_strb_q[1:0];
  assign wr_key = w_data_q[15:8];
  assign wr_low = w_data_q[7:0];
  assign hit_ctrl = aw_addr_q == {`WD_IDX_CTRL, 2'b00};
  assign hit_rst = aw_addr_q == {`WD_IDX_RST, 2'b00};
  assign hit_stat = aw_addr_q == {`WD_IDX_STAT, 2'b00};
  assign hit_mask = aw_addr_q == {`WD_IDX_MASK, 2'b00};
  assign wr_mapped = hit_ctrl || hit_rst || hit_stat || hit_mask;

  // Counter and control share one write address; the key picks the target.
  // Byte writes are dropped because they cannot carry the key.
  assign ctrl_wr = wr_fire && hit_ctrl && word_ok && wr_key == `WD_KEY_CTRL;
  assign cnt_wr = wr_fire && hit_ctrl && word_ok && wr_key == `WD_KEY_CNT;

  // The flag clears only by writing 0 after it was read as 1, or by a reset.
  assign ovf_clr = ctrl_wr && !wr_low[`WD_CTRL_OVF] && ovf_read_q;
  assign watchdog_reset_status_clr = wr_fire && hit_rst && word_ok && wr_key == `WD_KEY_CTRL
                    && wr_low == 8'h00;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  wd_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl_q.run),
    .cks(ctrl_q.cks),
    .tick(tick)
  );

  // A pending write steals the pulse, so overflow cannot fire on it either.
  assign overflow = tick && !cnt_wr && !chip_reset && wd_up_counter_q == 8'hff;
  assign wd_event = overflow && ctrl_q.mode && ctrl_q.run;

  // Halted means held at zero; the internal reset also clears the counter.
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset || !ctrl_q.run) begin
      wd_up_counter_q <= `WD_CNT_RESET;
    end else if (cnt_wr) begin
      wd_up_counter_q <= wr_low;
    end else if (tick) begin
      wd_up_counter_q <= wd_up_counter_q + 8'h01;
    end
  end

  // Control bits and overflow flag share one process because they form one
  // register. The internal reset returns them to idle, so the chip restarts in
  // interval mode, halted, until software arms it again. Set wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      ctrl_q.ovf <= 1'b0;
      ctrl_q.mode <= 1'b0;
      ctrl_q.run <= 1'b0;
      ctrl_q.cks <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q.mode <= wr_low[`WD_CTRL_MODE];
        ctrl_q.run <= wr_low[`WD_CTRL_RUN];
        ctrl_q.cks <= wr_low[2:0];
      end
      if (overflow) begin
        ctrl_q.ovf <= 1'b1;
      end else if (ovf_clr) begin
        ctrl_q.ovf <= 1'b0;
      end
    end
  end

  // Watchdog-reset status survives the internal reset; the pin or a keyed zero write to the reset register clears it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= '0;
    end else begin
      if (wd_event) begin
        rst_q.watchdog_reset_status <= 1'b1;
      end else if (watchdog_reset_status_clr) begin
        rst_q.watchdog_reset_status <= 1'b0;
      end
      if (wr_fire && hit_rst && word_ok && wr_key == `WD_KEY_CNT) begin
        rst_q.rstoe <= wr_low[`WD_RST_OE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset generation
  // ----------------------------------------------------------------
  // The chip reset starts at the same edge that sets the flag and status.
  wd_pulse_gen #(.LEN(`WD_RESET_CYCLES)) u_chip_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wd_event),
    .active(chip_reset)
  );

  // The shorter external pulse only runs when external output is enabled.
  wd_pulse_gen #(.LEN(`WD_EXT_RESET_CYCLES)) u_ext_rst (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wd_event && rst_q.rstoe),
    .active(ext_active)
  );

  assign ext_reset_n = !ext_active;

  // Level request: tracks the flag, so it stays up until software clears it.
  assign interval_interrupt = ctrl_q.ovf && !ctrl_q.mode;

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Sticky events; a new event in the clearing cycle stays set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (stat_q & ~((wr_fire && hit_stat && w_strb_q[0]) ? wr_low[1:0] : 2'h0))
                | {wd_event, overflow && !ctrl_q.mode};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= 2'h0;
    end else if (wr_fire && hit_mask && w_strb_q[0]) begin
      mask_q <= wr_low[1:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = wr_state_q == WR_RESP;
  assign s_axi_bresp = bresp_q;

  // Address and data are caught in either order; the response waits for both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 18'h00000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bresp_q <= `WD_RESP_OKAY;
      wr_state_q <= WR_IDLE;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= (s_axi_awaddr[31:18] == 14'h0000) ? s_axi_awaddr[17:0] : 18'h00001;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      unique case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            bresp_q <= wr_mapped ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
            wr_state_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_state_q <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  logic [17:0] rd_addr;
  logic rd_fire;

  assign rd_addr = s_axi_araddr[17:0];
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Data are captured at the address edge, the same edge that raises rvalid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `WD_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= `WD_RESP_OKAY;
      rdata_q <= 32'h00000000;
      if (s_axi_araddr[31:18] != 14'h0000) begin
        rresp_q <= `WD_RESP_SLVERR;
      end else if (rd_addr == {`WD_IDX_CTRL, 2'b00}) begin
        rdata_q[7:0] <= {ctrl_q.ovf, ctrl_q.mode, ctrl_q.run, `WD_CTRL_RSVD, ctrl_q.cks};
      end else if (rd_addr == {`WD_IDX_CNT, 2'b00}) begin
        rdata_q[7:0] <= wd_up_counter_q;
      end else if (rd_addr == {`WD_IDX_RST, 2'b00}) begin
        rdata_q[7:0] <= {rst_q.watchdog_reset_status, rst_q.rstoe, `WD_RST_RSVD};
      end else if (rd_addr == {`WD_IDX_STAT, 2'b00}) begin
        rdata_q[1:0] <= stat_q;
      end else if (rd_addr == {`WD_IDX_MASK, 2'b00}) begin
        rdata_q[1:0] <= mask_q;
      end else begin
        rresp_q <= `WD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Remember that software has seen the flag set; any control write re-arms.
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset) begin
      ovf_read_q <= 1'b0;
    end else if (rd_fire && rd_addr == {`WD_IDX_CTRL, 2'b00} && ctrl_q.ovf) begin
      ovf_read_q <= 1'b1;
    end else if (ctrl_wr) begin
      ovf_read_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Length of the current internal reset, for the duration check.
  always_ff @(posedge aclk) begin
    if (!aresetn || !chip_reset) begin
      rst_len_q <= 12'h000;
    end else begin
      rst_len_q <= rst_len_q + 12'h001;
    end
  end

  a_ovf_on_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> (ctrl_q.ovf && wd_up_counter_q == 8'h00))
    else $error("overflow flag not set with the counter wrap");

  a_wrap_from_ff: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ctrl_q.ovf) |-> ($past(wd_up_counter_q) == 8'hff && $past(tick)))
    else $error("overflow flag set without a wrap from all ones");

  a_interval_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (overflow && !ctrl_q.mode && !ovf_clr) |=> interval_interrupt [*2])
    else $error("interval interrupt missing after overflow");

  a_watchdog_reset_status_needs_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(rst_q.watchdog_reset_status) |-> $past(ctrl_q.mode && ctrl_q.run))
    else $error("watchdog reset status set while not armed");

  a_wd_same_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (overflow && ctrl_q.mode) |=> (rst_q.watchdog_reset_status && ctrl_q.ovf && chip_reset
                                  && !interval_interrupt))
    else $error("watchdog overflow did not set status, flag and reset together");

  a_reset_keeps_watchdog_reset_status: assert property (@(posedge aclk) disable iff (!aresetn)
    (chip_reset && $past(chip_reset) && !$past(watchdog_reset_status_clr)) |-> (!ctrl_q.ovf && rst_q.watchdog_reset_status))
    else $error("internal reset did not clear flag or lost status");

  a_reset_length: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(chip_reset) |-> rst_len_q == 12'(`WD_RESET_CYCLES))
    else $error("internal reset held for the wrong number of cycles");

  a_write_beats_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (cnt_wr && tick && ctrl_q.run && !chip_reset) |=> wd_up_counter_q == $past(wr_low))
    else $error("counter write lost to a count pulse");

  a_bad_key_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && hit_ctrl && wr_key != `WD_KEY_CTRL && wr_key != `WD_KEY_CNT && !chip_reset)
    |=> ($stable(ctrl_q.mode) && $stable(ctrl_q.run) && $stable(ctrl_q.cks)))
    else $error("control changed by a write without the key");

endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking testbench for the watchdog/interval timer with its AXI4-Lite slave.
// Assumes wd_defines.svh is on the include path and wd_timer is compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "wd_defines.svh"

module tb_top;
  // ----------------------------------------------------------------
  // Signals and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] A_CTRL = {14'h0, `WD_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_CNT = {14'h0, `WD_IDX_CNT, 2'b00};
  localparam logic [31:0] A_RST = {14'h0, `WD_IDX_RST, 2'b00};
  localparam logic [31:0] A_STAT = {14'h0, `WD_IDX_STAT, 2'b00};
  localparam logic [31:0] A_MASK = {14'h0, `WD_IDX_MASK, 2'b00};
  logic aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic interval_interrupt, chip_reset, ext_reset_n, irq;
  int n_mismatch = 0;
  int compares = 0;
  int n, n_ext;
  time t0, t1;

  wd_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .interval_interrupt(interval_interrupt), .chip_reset(chip_reset),
    .ext_reset_n(ext_reset_n), .irq(irq));

  // ----------------------------------------------------------------
  // Clock, checking and closing
  // ----------------------------------------------------------------
  // A 4 ns period gives the 250 MHz system clock.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The longest wait is one /32 overflow period, so this limit is generous.
  initial begin
    repeat (100000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------
  // Bus tasks: entered and left right after a rising edge
  // ----------------------------------------------------------------
  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [31:0] a, input logic [31:0] wd, input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    // One idle edge, so a following call never re-raises bready in this step.
    @(posedge aclk);
  endtask

  // Keyed word write: key in the upper byte, data in the lower byte.
  task automatic wk(input logic [31:0] a, input logic [7:0] key, input logic [7:0] low);
    wr(a, {16'h0000, key, low}, 4'hf);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] rdv);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rdv = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    // One idle edge, so a following call never re-raises rready in this step.
    @(posedge aclk);
  endtask

  // Counts edges until the level is seen high, giving up at the limit.
  task automatic wait_hi(ref logic sig, input int lim, output int cnt);
    cnt = 0;
    while (sig !== 1'b1 && cnt < lim) begin
      @(posedge aclk);
      cnt++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Interval mode at /2: flag, level interrupt, clear, period, mask.
  task automatic t_interval();
    rd(A_CTRL, d); chk(d, 32'h18);
    wk(A_MASK, 8'h00, 8'h01);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h20);
    wait_hi(interval_interrupt, 1000, n);
    t0 = $time;
    chk(interval_interrupt, 1'b1);
    chk(irq, 1'b1);
    rd(A_CTRL, d); chk(d, 32'hb8);
    rd(A_RST, d); chk(d, 32'h3f);
    rd(A_STAT, d); chk(d, 32'h01);
    chk(interval_interrupt, 1'b1);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h20);
    chk(interval_interrupt, 1'b0);
    wk(A_STAT, 8'h00, 8'h01);
    chk(irq, 1'b0);
    wait_hi(interval_interrupt, 1000, n);
    t1 = $time;
    chk(32'((t1 - t0) / 4), 32'd512);
    wk(A_MASK, 8'h00, 8'h00);
    rd(A_STAT, d); chk(d, 32'h01);
    chk(irq, 1'b0);
    // Halt first, so a later change of the divider starts from a clean count.
    rd(A_CTRL, d);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h00);
    rd(A_CNT, d); chk(d, 32'h00);
    chk(interval_interrupt, 1'b0);
    wk(A_STAT, 8'h00, 8'h01);
  endtask

  // Keys, byte strobes, counter load, unmapped access and the /32 rate.
  task automatic t_keys();
    wk(A_CTRL, 8'h33, 8'h20);
    chk(r, `WD_RESP_OKAY);
    rd(A_CTRL, d); chk(d, 32'h18);
    wr(A_CTRL, {16'h0000, `WD_KEY_CTRL, 8'h20}, 4'h1);
    rd(A_CTRL, d); chk(d, 32'h18);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h27);
    wk(A_CTRL, `WD_KEY_CNT, 8'h80);
    rd(A_CNT, d); chk(d, 32'h80);
    chk(r, `WD_RESP_OKAY);
    wk(32'h0000_0100, `WD_KEY_CTRL, 8'h20);
    chk(r, `WD_RESP_SLVERR);
    rd(32'h0000_0100, d); chk(r, `WD_RESP_SLVERR);
    chk(d, 32'h00);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h00);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h21);
    wait_hi(interval_interrupt, 9000, n);
    chk(n >= 8190 && n <= 8196, 1'b1);
    rd(A_CTRL, d);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h00);
    wk(A_STAT, 8'h00, 8'h01);
  endtask

  // Watchdog overflow: chip reset length, external pulse, sticky status.
  task automatic t_watchdog();
    wk(A_RST, `WD_KEY_CNT, 8'h40);
    rd(A_RST, d); chk(d, 32'h7f);
    wk(A_CTRL, `WD_KEY_CTRL, 8'h60);
    wk(A_CTRL, `WD_KEY_CNT, 8'hf0);
    // The 0xf0 load lands on a count pulse; the wrap follows 16 pulses later.
    wait_hi(chip_reset, 200, n);
    chk(n, 31);
    chk(chip_reset, 1'b1);
    chk(interval_interrupt, 1'b0);
    n = 0;
    n_ext = 0;
    while (chip_reset === 1'b1 && n < 1000) begin
      if (ext_reset_n === 1'b0) n_ext++;
      n++;
      @(posedge aclk);
    end
    chk(n, 518);
    chk(n_ext, `WD_EXT_RESET_CYCLES);
    rd(A_RST, d); chk(d, 32'hff);
    rd(A_CTRL, d); chk(d, 32'h18);
    rd(A_STAT, d); chk(d, 32'h02);
    wk(A_RST, `WD_KEY_CTRL, 8'h00);
    rd(A_RST, d); chk(d, 32'h7f);
    wk(A_STAT, 8'h00, 8'h03);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_interval();
    t_keys();
    t_watchdog();
    results();
  end
endmodule
`default_nettype wire
